// ===== ssx_defs.vh
// Constants for the sleep, subtract and swap execution block
// Assumes a 14-bit instruction word and an 8-bit data path
`ifndef SSX_DEFS_VH
`define SSX_DEFS_VH
// Opcode patterns
`define OP_SLEEP_WORD   14'h0063
`define OP_LITSUB_HI    5'h1E
`define OP_FILESUB_HI   6'h02
`define OP_SWAP_HI      6'h0E
// Quarter cycle codes
`define Q1              2'h0
`define Q2              2'h1
`define Q3              2'h2
`define Q4              2'h3
// Watchdog clear value
`define WDOG_CLEAR      8'h00
// Status reset values
`define TIMEOUT_RST     1'b1
`define POWERDOWN_RST   1'b1
`endif

// ===== sub_flags_unit.v
// Subtracter producing the difference and the carry, digit-carry and zero
// Assumes purely combinational use inside the execution block
`timescale 1ns/1ps
module sub_flags_unit #(
   parameter W = 8
) (
   input  wire [W-1:0] minuend,
   input  wire [W-1:0] subtrahend,
   output wire [W-1:0] diff,
   output wire         carry,
   output wire         digit_carry,
   output wire         zero
);
   wire [W:0] full;
   wire [4:0] low;

   // Carry is an inverted borrow: set when no borrow occurs
   assign full        = {1'b0, minuend} + {1'b0, ~subtrahend} + 1'b1;
   assign low         = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                        + 5'h01;
   assign diff        = full[W-1:0];
   assign carry       = full[W];
   assign digit_carry = low[4];
   assign zero        = (full[W-1:0] == {W{1'b0}});
endmodule // sub_flags_unit

// ===== sleep_subtract_swap_exec.v
// Execution of power-down, literal subtract, file subtract and nibble swap
// Assumes the core presents the instruction word before Q2 and file data before Q3,
// and that CE stalls the whole quarter sequence
// Assumes the watchdog and oscillator act on WDOG_CLR and OSC_STOP,
// and that the core raises WAKE once it wants the sequence to resume
// Assumes the file register bank writes FILE_WDATA at FILE_ADDR while
// FILE_WE is high for one enabled cycle
//
// Function
// - Power-down: idle Q2,Q3; sleep at Q4
// - Power-down clears powerdown_flag_n, sets timeout_flag_n
// - Power-down clears watchdog counter and prescaler
// - Literal minus work into work, flags
// - Literal subtract matches 11 110x, low byte
// - File minus work to destination, flags
// - Carry is inverted borrow on subtracts
`timescale 1ns/1ps
`include "ssx_defs.vh"
module sleep_subtract_swap_exec #(
   parameter DW = 8,
   parameter IW = 14
) (
   input  wire          CLK_SYS,
   input  wire          RESETN,
   input  wire          CE,
   input  wire          WAKE,
   input  wire [IW-1:0] INSTR,
   input  wire [DW-1:0] FILE_RDATA,
   // File register access
   output reg  [6:0]    FILE_ADDR,
   output reg  [DW-1:0] FILE_WDATA,
   output reg           FILE_WE,
   // Working register and flags
   output reg  [DW-1:0] WORK,
   output reg           CARRY,
   output reg           DIGIT_CARRY,
   output reg           ZERO,
   // Power-down status, watchdog and oscillator control, quarter phase
   output reg           TIMEOUT_FLAG_N,
   output reg           POWERDOWN_FLAG_N,
   output reg           WDOG_CLR,
   output reg           OSC_STOP,
   output reg  [1:0]    QPHASE
);
   ////////////////////////////////////////////////////////////////////////
   // Decode
   reg  [IW-1:0] ir_r;
   reg  [DW-1:0] fdat_r;
   wire          is_sleep;
   wire          is_litsub;
   wire          is_filesub;
   wire          is_swap;
   wire          dest_file;
   wire [DW-1:0] sub_a;
   wire [DW-1:0] sub_d;
   wire          sub_c;
   wire          sub_dc;
   wire          sub_z;
   wire [DW-1:0] swapped;
   // Commit values worked out before the Q4 edge
   reg  [DW-1:0] work_nxt;
   reg  [DW-1:0] fwd_nxt;
   reg           fwe_nxt;
   reg           carry_nxt;
   reg           dc_nxt;
   reg           zero_nxt;
   reg           pd_nxt;
   reg           to_nxt;
   reg           wclr_nxt;
   reg           stop_nxt;

   // Decode works on the word latched at Q1, so a core that changes
   // INSTR early for the next cycle cannot disturb the current one;
   // the power-down word is matched in full, the others by their top bits
   // and any word that matches nothing simply passes without effect

   assign is_sleep   = (ir_r == `OP_SLEEP_WORD);
   assign is_litsub  = (ir_r[13:9] == `OP_LITSUB_HI);
   assign is_filesub = (ir_r[13:8] == `OP_FILESUB_HI);
   assign is_swap    = (ir_r[13:8] == `OP_SWAP_HI);
   assign dest_file  = ir_r[7];
   // Minuend is the literal byte or the file value
   assign sub_a      = is_litsub ? ir_r[7:0] : fdat_r;
   assign swapped    = {fdat_r[3:0], fdat_r[7:4]};

   // One subtracter serves both subtract forms; only the minuend differs,
   // and the work register is always the subtrahend
   sub_flags_unit #(
      .W           (DW)
   ) u_sub (
      .minuend     (sub_a),
      .subtrahend  (WORK),
      .diff        (sub_d),
      .carry       (sub_c),
      .digit_carry (sub_dc),
      .zero        (sub_z)
   );

   ////////////////////////////////////////////////////////////////////////
   // Commit values
   // Everything written at the end of Q4 is worked out here, so the
   // sequencer below only copies it; unknown words leave all state alone
   always @* begin
      work_nxt  = WORK;
      fwd_nxt   = FILE_WDATA;
      fwe_nxt   = 1'b0;
      carry_nxt = CARRY;
      dc_nxt    = DIGIT_CARRY;
      zero_nxt  = ZERO;
      pd_nxt    = POWERDOWN_FLAG_N;
      to_nxt    = TIMEOUT_FLAG_N;
      wclr_nxt  = 1'b0;
      stop_nxt  = 1'b0;
      if (is_sleep) begin
         // Status, watchdog clear and oscillator stop, all in the one Q4 commit
         pd_nxt   = 1'b0;
         to_nxt   = 1'b1;
         wclr_nxt = 1'b1;
         stop_nxt = 1'b1;
      end else if (is_litsub) begin
         // Literal minus work always lands in the work register
         work_nxt  = sub_d;
         carry_nxt = sub_c;
         dc_nxt    = sub_dc;
         zero_nxt  = sub_z;
      end else if (is_filesub) begin
         // File minus work; flags follow the difference
         carry_nxt = sub_c;
         dc_nxt    = sub_dc;
         zero_nxt  = sub_z;
         if (dest_file) begin
            fwd_nxt = sub_d;
            fwe_nxt = 1'b1;
         end else begin
            work_nxt = sub_d;
         end
      end else if (is_swap) begin
         // Nibble swap leaves every flag as it was
         if (dest_file) begin
            fwd_nxt = swapped;
            fwe_nxt = 1'b1;
         end else begin
            work_nxt = swapped;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Quarter sequencer and execution
   // Each enabled edge moves one quarter on; Q1 takes the word, Q2 the
   // file operand, Q3 only lets the subtracter settle, Q4 commits.
   // Once asleep the quarter counter rests on Q1 and only WAKE restarts
   // it, so the first word after waking is decoded from scratch.
   // A low CE holds every register, pulses included, so a stall in the
   // middle of a cycle neither repeats nor drops a write.
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         // Status bits come out of reset set; all else clear
         QPHASE           <= `Q1;
         ir_r             <= {IW{1'b0}};
         fdat_r           <= {DW{1'b0}};
         FILE_ADDR        <= 7'h00;
         FILE_WDATA       <= {DW{1'b0}};
         FILE_WE          <= 1'b0;
         WORK             <= {DW{1'b0}};
         CARRY            <= 1'b0;
         DIGIT_CARRY      <= 1'b0;
         ZERO             <= 1'b0;
         TIMEOUT_FLAG_N   <= `TIMEOUT_RST;
         POWERDOWN_FLAG_N <= `POWERDOWN_RST;
         WDOG_CLR         <= 1'b0;
         OSC_STOP         <= 1'b0;
      end else if (CE) begin
         // Pulses last one enabled cycle unless Q4 raises them again
         FILE_WE  <= 1'b0;
         WDOG_CLR <= 1'b0;
         if (OSC_STOP) begin
            // Asleep: only a wake request restarts the sequence
            if (WAKE) begin
               OSC_STOP <= 1'b0;
               QPHASE   <= `Q1;
            end
         end else begin
            QPHASE <= QPHASE + 2'h1;
            case (QPHASE)
               `Q1: begin
                  // Decode: latch instruction and drive file address
                  // The address goes out now so the operand is ready by Q2
                  ir_r      <= INSTR;
                  FILE_ADDR <= INSTR[6:0];
               end
               `Q2: begin
                  // Read the file operand; power-down idles
                  // Literal forms take it too but never use it
                  fdat_r <= FILE_RDATA;
               end
               `Q3: begin
                  // Processing is combinational; nothing latched
                  // Power-down still idles here
               end
               `Q4: begin
                  // Commit the results worked out above
                  WORK             <= work_nxt;
                  FILE_WDATA       <= fwd_nxt;
                  FILE_WE          <= fwe_nxt;
                  CARRY            <= carry_nxt;
                  DIGIT_CARRY      <= dc_nxt;
                  ZERO             <= zero_nxt;
                  POWERDOWN_FLAG_N <= pd_nxt;
                  TIMEOUT_FLAG_N   <= to_nxt;
                  WDOG_CLR         <= wclr_nxt;
                  OSC_STOP         <= stop_nxt;
               end
               default: begin
                  QPHASE <= `Q1;
               end
            endcase
         end
      end
   end
endmodule // sleep_subtract_swap_exec

// ===== ssx_props.sv
// Checker of the sleep, subtract and swap execution block
// Assumes one clock domain and an unbroken four-quarter instruction cycle
`timescale 1ns/1ps
`include "ssx_defs.vh"
module ssx_props #(parameter DW = 8, parameter IW = 14) (
   input wire          CLK_SYS, RESETN, CE, WAKE, FILE_WE, CARRY,
   input wire          DIGIT_CARRY, ZERO, TIMEOUT_FLAG_N, POWERDOWN_FLAG_N,
   input wire          WDOG_CLR, OSC_STOP,
   input wire [IW-1:0] INSTR,
   input wire [DW-1:0] FILE_RDATA, FILE_WDATA, WORK,
   input wire [6:0]    FILE_ADDR,
   input wire [1:0]    QPHASE);
   reg  [IW-1:0] ir_r;
   reg  [DW-1:0] fr_r;
   // Keep the word and file data that the block has taken
   always @(posedge CLK_SYS) begin
      if (CE && !OSC_STOP && QPHASE == `Q1) ir_r <= INSTR;
      if (CE && !OSC_STOP && QPHASE == `Q2) fr_r <= FILE_RDATA;
   end
   wire          q4   = CE && !OSC_STOP && QPHASE == `Q4;
   wire          slp  = ir_r == `OP_SLEEP_WORD;
   wire          slp4 = q4 && slp;
   wire          lsub = ir_r[13:9] == `OP_LITSUB_HI;
   wire          fsub = ir_r[13:8] == `OP_FILESUB_HI;
   wire          swp  = ir_r[13:8] == `OP_SWAP_HI;
   wire [DW-1:0] m    = lsub ? ir_r[7:0] : fr_r;
   wire [DW-1:0] sw   = {fr_r[3:0], fr_r[7:4]};
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   a_quarter_step: assert property (CE && !OSC_STOP |=>
      QPHASE == $past(QPHASE) + 2'h1) else $error("quarter skipped");
   a_sleep_idle: assert property (CE && slp && QPHASE inside {`Q2, `Q3}
      |=> !OSC_STOP && !WDOG_CLR) else $error("sleep too early");
   a_sleep_status: assert property (slp4 |=> OSC_STOP &&
      !POWERDOWN_FLAG_N && TIMEOUT_FLAG_N && $stable({CARRY, ZERO}))
      else $error("sleep status wrong");
   a_wdog_clear: assert property (slp4 |=> WDOG_CLR ##1 !WDOG_CLR)
      else $error("watchdog clear wrong");
   a_litsub_work: assert property (q4 && lsub |=>
      WORK == m - $past(WORK) && ZERO == (WORK == 8'h00))
      else $error("literal subtract wrong");
   a_sub_carry: assert property (q4 && (lsub || fsub) |=>
      CARRY == (m >= $past(WORK)) &&
      DIGIT_CARRY == (m[3:0] >= $past(WORK[3:0]))) else $error("carry wrong");
   a_filesub_dest: assert property (q4 && fsub |=> (ir_r[7] ?
      FILE_WE && FILE_WDATA == m - $past(WORK) :
      !FILE_WE && WORK == m - $past(WORK))) else $error("file subtract");
   a_swap_dest: assert property (q4 && swp |=>
      $stable({CARRY, DIGIT_CARRY, ZERO}) &&
      (ir_r[7] ? FILE_WE && FILE_WDATA == sw : WORK == sw))
      else $error("swap wrong");
   c_sleep: cover property (slp4);
   c_file_sub: cover property (q4 && fsub && ir_r[7]);
   c_swap: cover property (q4 && swp && !ir_r[7]);
endmodule // ssx_props
bind sleep_subtract_swap_exec ssx_props #(.DW(DW), .IW(IW)) ssx_props_inst (.*);

// ===== sleep_subtract_swap_exec_tb.sv
// Self-checking bench for the sleep, subtract and swap execution block
// Assumes the checker is compiled and bound beside the design
`timescale 1ns/1ps
module sleep_subtract_swap_exec_tb;
   reg        CLK_SYS = 0, RESETN = 0, CE = 1, WAKE = 0;
   reg [13:0] INSTR = 0;
   reg [7:0]  FILE_RDATA = 0;
   reg [31:0] seed = 32'hF6FFE461;
   wire [6:0] FILE_ADDR;
   wire [7:0] FILE_WDATA, WORK;
   wire [1:0] QPHASE;
   wire       FILE_WE, CARRY, DIGIT_CARRY, ZERO, TIMEOUT_FLAG_N;
   wire       POWERDOWN_FLAG_N, WDOG_CLR, OSC_STOP;
   integer    miscompares = 0, num_checks = 0, w = 0, c = 0, dc = 0, z = 0;
   integer    m, r, k;
   sleep_subtract_swap_exec sleep_subtract_swap_exec_inst (.*);
   initial forever #25 CLK_SYS = ~CLK_SYS;
   ////////////////////////////////////////////////////////////////////////
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   task chk(input [7:0] s, input [7:0] e);
      begin
         num_checks = num_checks + 1;
         if (s !== e) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: saw %h wanted %h", $time, s, e);
         end
      end
   endtask
   // One instruction through the model and the design
   task ex(input [13:0] i, input [7:0] f);
      begin
         INSTR = i;
         FILE_RDATA = f;
         m = i[13] ? i[7:0] : f;
         @(negedge CLK_SYS);
         if (i[1]) begin
            CE = 0; // Freeze one cycle after the word is taken
            @(negedge CLK_SYS);
            chk(QPHASE, 2'h1);
            CE = 1;
         end
         repeat (3) @(negedge CLK_SYS);
         chk(QPHASE, 2'h0);
         chk(FILE_ADDR, i[6:0]);
         if (i[13] || !i[11]) begin
            r = m - w;
            c = r >= 0;
            dc = m % 16 >= w % 16;
            r = r & 255;
            z = r == 0;
         end else r = {f[3:0], f[7:4]};
         if (i[13] || !i[7]) w = r;
         else chk(FILE_WDATA, r);
         chk(FILE_WE, !(i[13] || !i[7]));
         chk(WORK, w);
         chk({CARRY, DIGIT_CARRY, ZERO}, {c[0], dc[0], z[0]});
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Random subtracts and swaps, a zero result, then sleep and wake
   initial begin
      repeat (4) @(negedge CLK_SYS);
      RESETN = 1;
      for (k = 0; k < 60; k = k + 1) begin
         seed = xs(seed);
         ex(k % 3 == 0 ? {5'h1E, seed[8:0]} :
            {k % 3 == 1 ? 6'h02 : 6'h0E, seed[7:0]}, seed[31:24]);
      end
      ex({6'h3C, w[7:0]}, 8'h00);
      INSTR = 14'h0063;
      repeat (4) @(negedge CLK_SYS);
      chk({POWERDOWN_FLAG_N, TIMEOUT_FLAG_N, OSC_STOP, WDOG_CLR}, 4'h7);
      INSTR = 14'h0000;
      repeat (3) @(negedge CLK_SYS);
      chk({OSC_STOP, WDOG_CLR}, 2'h2);
      WAKE = 1;
      @(negedge CLK_SYS);
      WAKE = 0;
      ex(14'h3C80, 8'h00);
      print_verdict;
   end
   // Cut a hang short
   initial begin
      #100000;
      miscompares = miscompares + 1;
      print_verdict;
   end
endmodule // sleep_subtract_swap_exec_tb
